/* File: hdl/sdes_pkg.sv */
// Package with register map, bit positions and timing constants of the error-status block.
package sdes_pkg;
  localparam int SDES_AW = 4;
  localparam logic [3:0] SDES_ADDR_ERRSTAT = 4'h0;
  localparam logic [3:0] SDES_ADDR_STATEN = 4'h1;
  localparam logic [3:0] SDES_ADDR_SIGEN = 4'h2;
  localparam logic [3:0] SDES_ADDR_CTRL = 4'h3;
  localparam logic [3:0] SDES_ADDR_STATE = 4'h4;
  localparam logic [3:0] SDES_ADDR_RESP = 4'h5;
  localparam int SDES_BIT_CMDTO = 0;
  localparam int SDES_BIT_CRC = 1;
  localparam int SDES_BIT_END = 2;
  localparam int SDES_BIT_IDX = 3;
  localparam int SDES_BIT_DTO = 4;
  localparam int SDES_NFLAG = 5;
  localparam logic [4:0] SDES_FLAGS_RST = 5'h00;
  localparam logic [4:0] SDES_EN_RST = 5'h00;
  localparam logic [15:0] SDES_TIMEOUT_RST = 16'h0040;
  localparam int SDES_CMD_BITS = 48;
  localparam int SDES_RESP_BITS = 48;
  localparam logic [5:0] SDES_START_PAT = 6'h01;
  localparam logic [6:0] SDES_CRC_POLY = 7'h09;
  typedef enum logic [5:0] {
    SDES_IDLE = 6'h01,
    SDES_SEND = 6'h02,
    SDES_WAIT = 6'h04,
    SDES_RECV = 6'h08,
    SDES_BUSY = 6'h10,
    SDES_DATA = 6'h20
  } sdes_state_t;
endpackage

/* File: hdl/sdes_crc7.sv */
// Serial CRC7 generator used for command and response checking.
`timescale 1ns/1ps
module sdes_crc7 (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst,
  // Control.
  input wire logic clear,
  input wire logic shift,
  input wire logic din,
  // Result.
  output logic [6:0] crc
);
  import sdes_pkg::*;
  logic fb;
  assign fb = din ^ crc[6];
  always_ff @(posedge sys_clk) begin
    if (rst || clear) begin
      crc <= 7'h00;
    end else if (shift) begin
      crc <= {crc[5:0], 1'b0} ^ (fb ? SDES_CRC_POLY : 7'h00);
    end
  end
endmodule

/* File: hdl/sdes_top.sv */
// Error-status logic of a memory card host: command engine, checks and flag registers.
//
// The address-and-strobe port and the address map were left to the implementer.
`timescale 1ns/1ps
module sdes_top (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst,
  // Register port.
  input wire logic [sdes_pkg::SDES_AW-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Card link.
  input wire logic card_clk,
  input wire logic cmd_in,
  output logic cmd_out,
  output logic cmd_oe,
  input wire logic dat0_in,
  // Interrupt.
  output logic irq
);
  import sdes_pkg::*;

  logic [4:0] flags_r;
  logic [4:0] stat_en_r;
  logic [4:0] sig_en_r;
  logic [15:0] timeout_r;
  logic [5:0] cmd_index_r;
  logic [31:0] cmd_arg_r;
  logic resp_busy_r;
  logic wr_crcstat_r;
  logic rd_data_r;
  logic go_pulse;
  sdes_state_t state_r;
  logic [5:0] bitcnt_r;
  logic [47:0] shreg_r;
  logic [15:0] tcnt_r;
  logic [5:0] resp_idx_r;
  logic [2:0] clk_sync_r;
  logic [1:0] cmd_sync_r;
  logic [1:0] dat_sync_r;
  logic clk_rise;
  logic clk_fall;
  logic cmd_s;
  logic dat_s;
  logic drove_one_r;
  logic [4:0] ev;
  logic [4:0] clr;
  logic crc_clear;
  logic crc_shift;
  logic crc_din;
  logic [6:0] crc_val;
  logic send_bit;
  logic [31:0] rdata_nxt;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
    return a == off;
  endfunction

  // Card clock and lines pass two flip-flops before use.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      clk_sync_r <= 3'h0;
      cmd_sync_r <= 2'h3;
      dat_sync_r <= 2'h3;
    end else begin
      clk_sync_r <= {clk_sync_r[1:0], card_clk};
      cmd_sync_r <= {cmd_sync_r[0], cmd_in};
      dat_sync_r <= {dat_sync_r[0], dat0_in};
    end
  end
  assign clk_rise = clk_sync_r[1] & ~clk_sync_r[2];
  assign clk_fall = ~clk_sync_r[1] & clk_sync_r[2];
  assign cmd_s = cmd_sync_r[1];
  assign dat_s = dat_sync_r[1];

  // Control register writes.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      stat_en_r <= SDES_EN_RST;
      sig_en_r <= SDES_EN_RST;
      timeout_r <= SDES_TIMEOUT_RST;
      cmd_index_r <= 6'h00;
      cmd_arg_r <= 32'h0000_0000;
      resp_busy_r <= 1'b0;
      wr_crcstat_r <= 1'b0;
      rd_data_r <= 1'b0;
      go_pulse <= 1'b0;
    end else begin
      go_pulse <= 1'b0;
      if (reg_wr && hit(reg_addr, SDES_ADDR_STATEN)) begin
        stat_en_r <= reg_wdata[4:0];
      end
      if (reg_wr && hit(reg_addr, SDES_ADDR_SIGEN)) begin
        sig_en_r <= reg_wdata[4:0];
      end
      if (reg_wr && hit(reg_addr, SDES_ADDR_RESP)) begin
        cmd_arg_r <= reg_wdata;
      end
      if (reg_wr && hit(reg_addr, SDES_ADDR_CTRL)) begin
        cmd_index_r <= reg_wdata[5:0];
        resp_busy_r <= reg_wdata[6];
        wr_crcstat_r <= reg_wdata[7];
        rd_data_r <= reg_wdata[8];
        go_pulse <= reg_wdata[9] && (state_r == SDES_IDLE);
        timeout_r <= reg_wdata[31:16];
      end
    end
  end

  // Command engine: send, wait for response, receive, then busy or data wait.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_r <= SDES_IDLE;
      bitcnt_r <= 6'h00;
      shreg_r <= 48'h0;
      tcnt_r <= 16'h0000;
      resp_idx_r <= 6'h00;
      cmd_out <= 1'b1;
      cmd_oe <= 1'b0;
      drove_one_r <= 1'b0;
    end else begin
      case (state_r)
        SDES_IDLE: begin
          cmd_oe <= 1'b0;
          cmd_out <= 1'b1;
          drove_one_r <= 1'b0;
          if (go_pulse) begin
            shreg_r <= {2'b01, cmd_index_r, cmd_arg_r, 8'h00};
            bitcnt_r <= 6'h00;
            state_r <= SDES_SEND;
          end
        end
        SDES_SEND: begin
          if (clk_rise && drove_one_r && cmd_oe && !cmd_s) begin
            cmd_oe <= 1'b0;
            drove_one_r <= 1'b0;
            state_r <= SDES_IDLE;
          end else if (clk_fall) begin
            if (bitcnt_r == 6'(SDES_CMD_BITS)) begin
              cmd_oe <= 1'b0;
              drove_one_r <= 1'b0;
              tcnt_r <= 16'h0000;
              bitcnt_r <= 6'h00;
              state_r <= SDES_WAIT;
            end else begin
              cmd_oe <= 1'b1;
              cmd_out <= send_bit;
              drove_one_r <= send_bit;
              shreg_r <= {shreg_r[46:0], 1'b0};
              bitcnt_r <= bitcnt_r + 6'd1;
            end
          end
        end
        SDES_WAIT: begin
          if (clk_rise) begin
            if (!cmd_s) begin
              bitcnt_r <= 6'd1;
              shreg_r <= 48'h0;
              state_r <= SDES_RECV;
            end else if (tcnt_r == timeout_r) begin
              state_r <= SDES_IDLE;
            end else begin
              tcnt_r <= tcnt_r + 16'd1;
            end
          end
        end
        SDES_RECV: begin
          if (clk_rise) begin
            shreg_r <= {shreg_r[46:0], cmd_s};
            bitcnt_r <= bitcnt_r + 6'd1;
            if (bitcnt_r == 6'd7) begin
              resp_idx_r <= {shreg_r[4:0], cmd_s};
            end
            if (bitcnt_r == 6'(SDES_RESP_BITS - 1)) begin
              tcnt_r <= 16'h0000;
              state_r <= resp_busy_r ? SDES_BUSY :
                ((wr_crcstat_r || rd_data_r) ? SDES_DATA : SDES_IDLE);
            end
          end
        end
        SDES_BUSY: begin
          if (clk_rise) begin
            if (dat_s || tcnt_r == timeout_r) begin
              tcnt_r <= 16'h0000;
              state_r <= (wr_crcstat_r || rd_data_r) ? SDES_DATA : SDES_IDLE;
            end else begin
              tcnt_r <= tcnt_r + 16'd1;
            end
          end
        end
        SDES_DATA: begin
          if (clk_rise) begin
            if (!dat_s || tcnt_r == timeout_r) begin
              state_r <= SDES_IDLE;
            end else begin
              tcnt_r <= tcnt_r + 16'd1;
            end
          end
        end
        default: begin
          state_r <= SDES_IDLE;
          cmd_oe <= 1'b0;
        end
      endcase
    end
  end

  // CRC runs over the 40 leading bits of each command or response.
  assign crc_clear = (state_r == SDES_IDLE) || (state_r == SDES_WAIT && clk_rise && !cmd_s);
  assign crc_shift = (state_r == SDES_SEND) ? (clk_fall && bitcnt_r < 6'd40) :
    (state_r == SDES_RECV && clk_rise && bitcnt_r < 6'd40);
  assign crc_din = (state_r == SDES_SEND) ? shreg_r[47] : cmd_s;

  // Frame bit on the line: payload, then the held CRC most significant bit first, then end bit.
  assign send_bit = (bitcnt_r >= 6'h28 && bitcnt_r < 6'h2F) ? crc_val[3'(6'h2E - bitcnt_r)] :
    ((bitcnt_r == 6'h2F) ? 1'b1 : shreg_r[47]);

  sdes_crc7 u_crc (
    .sys_clk(sys_clk),
    .rst(rst),
    .clear(crc_clear),
    .shift(crc_shift),
    .din(crc_din),
    .crc(crc_val)
  );

  // Error events, each one sys_clk cycle long.
  always_comb begin
    ev = 5'h00;
    if (state_r == SDES_SEND && clk_rise && drove_one_r && cmd_oe && !cmd_s) begin
      ev[SDES_BIT_CRC] = 1'b1;
      ev[SDES_BIT_CMDTO] = 1'b1;
    end
    if (state_r == SDES_WAIT && clk_rise && cmd_s && tcnt_r == timeout_r) begin
      ev[SDES_BIT_CMDTO] = 1'b1;
    end
    if (state_r == SDES_RECV && clk_rise) begin
      if (bitcnt_r == 6'd8 && resp_idx_r != cmd_index_r) begin
        ev[SDES_BIT_IDX] = 1'b1;
      end
      if (bitcnt_r == 6'd47) begin
        ev[SDES_BIT_END] = !cmd_s;
        ev[SDES_BIT_CRC] = (shreg_r[6:0] != crc_val);
      end
    end
    if ((state_r == SDES_BUSY || state_r == SDES_DATA) && clk_rise) begin
      if (state_r == SDES_BUSY ? (!dat_s && tcnt_r == timeout_r) :
          (dat_s && tcnt_r == timeout_r)) begin
        ev[SDES_BIT_DTO] = 1'b1;
      end
    end
  end

  // Sticky flags: write one to clear, set wins over clear.
  assign clr = (reg_wr && hit(reg_addr, SDES_ADDR_ERRSTAT)) ? reg_wdata[4:0] : 5'h00;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      flags_r <= SDES_FLAGS_RST;
    end else begin
      flags_r <= (flags_r & ~clr) | (ev & stat_en_r);
    end
  end

  // Interrupt output.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(flags_r & sig_en_r);
    end
  end

  // Read data appear in the cycle after the read strobe.
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    case (reg_addr)
      SDES_ADDR_ERRSTAT: rdata_nxt = {27'h0, flags_r};
      SDES_ADDR_STATEN: rdata_nxt = {27'h0, stat_en_r};
      SDES_ADDR_SIGEN: rdata_nxt = {27'h0, sig_en_r};
      SDES_ADDR_CTRL: rdata_nxt = {timeout_r, 6'h00, 1'b0, rd_data_r, wr_crcstat_r,
        resp_busy_r, cmd_index_r};
      SDES_ADDR_STATE: rdata_nxt = {20'h0, resp_idx_r, state_r};
      SDES_ADDR_RESP: rdata_nxt = cmd_arg_r;
      default: rdata_nxt = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= reg_rd ? rdata_nxt : 32'h0000_0000;
    end
  end
endmodule

/* File: verif/sdes_top_monitor.sv */
// Checker of flag, interrupt and command line behaviour of the error-status block.
`timescale 1ns/1ps
module sdes_chk (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst,
  // Register port.
  input wire logic [sdes_pkg::SDES_AW-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // Card link and interrupt.
  input wire logic card_clk,
  input wire logic cmd_in,
  input wire logic cmd_out,
  input wire logic cmd_oe,
  input wire logic irq
);
  import sdes_pkg::*;
  logic [4:0] sig_r, seen_r;
  logic [3:0] calm_r;
  logic go_r, dto_r;
  wire go = reg_wr && reg_addr == SDES_ADDR_CTRL && reg_wdata[9];
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sig_r <= 5'h00;
      seen_r <= 5'h00;
      go_r <= 1'b0;
      dto_r <= 1'b0;
      calm_r <= 4'h0;
    end else begin
      if (reg_wr && reg_addr == SDES_ADDR_SIGEN) sig_r <= reg_wdata[4:0];
      if (reg_wr && reg_addr == SDES_ADDR_STATEN) seen_r <= seen_r | reg_wdata[4:0];
      if (go) go_r <= 1'b1;
      if (go && |reg_wdata[8:6]) dto_r <= 1'b1;
      calm_r <= $changed(card_clk) ? 4'h0 : calm_r + {3'h0, calm_r != 4'hF};
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_rd_flags;
    reg_rd && reg_addr == SDES_ADDR_ERRSTAT ##1 1'b1;
  endsequence
  sequence s_conflict;
    $rose(card_clk) && cmd_oe && cmd_out && !cmd_in;
  endsequence
  sequence s_clear;
    calm_r == 4'hF && reg_wr && reg_addr == SDES_ADDR_ERRSTAT && reg_wdata[4:0] == 5'h1F
      ##1 reg_rd && reg_addr == SDES_ADDR_ERRSTAT ##1 calm_r == 4'hF;
  endsequence
  a_rst_quiet: assert property ($fell(rst) |-> !irq && !cmd_oe && reg_rdata == 32'h0)
    else $error("outputs not idle after reset");
  a_flags_clean: assert property (s_rd_flags |-> go_r || reg_rdata == 32'h0)
    else $error("flag set before any command");
  a_stat_gate: assert property (s_rd_flags |-> (reg_rdata[4:0] & ~seen_r) == 5'h00)
    else $error("flag set without status enable");
  a_irq_mask: assert property ((sig_r == 5'h00) [*3] |-> !irq)
    else $error("interrupt while all masked");
  a_irq_level: assert property (s_rd_flags ##0 $stable(sig_r) |->
    irq == |(reg_rdata[4:0] & sig_r)) else $error("interrupt differs from flags");
  a_dto_cause: assert property (s_rd_flags |-> !reg_rdata[SDES_BIT_DTO] || dto_r)
    else $error("data timeout without data wait");
  a_conflict_stop: assert property (s_conflict |-> ##[1:12] !cmd_oe)
    else $error("command line kept after conflict");
  a_w1c_clear: assert property (s_clear |-> reg_rdata[4:0] == 5'h00)
    else $error("flags not cleared by write");
endmodule
bind sdes_top sdes_chk i_chk (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .card_clk, .cmd_in, .cmd_out, .cmd_oe, .irq);

/* File: verif/sdes_card.sv */
// Card model that clocks the link and answers commands on a pulled-up command line.
`timescale 1ns/1ps
module sdes_card (
  // Link.
  input wire logic run,
  output logic card_clk,
  input wire logic cmd_out,
  input wire logic cmd_oe,
  output logic cmd_in,
  // Response control.
  input wire logic [2:0] mode,
  input wire logic [5:0] idx
);
  logic [47:0] rsp;
  logic [47:0] cmd_sh;
  logic drv, bit_v;
  function automatic logic [6:0] crc7(input logic [39:0] d);
    logic fb;
    crc7 = 7'h00;
    for (int i = 39; i >= 0; i--) begin
      fb = d[i] ^ crc7[6];
      crc7 = {crc7[5:0], 1'b0} ^ (fb ? 7'h09 : 7'h00);
    end
  endfunction
  assign cmd_in = (mode == 3'h5 && cmd_oe) ? 1'b0 : cmd_oe ? cmd_out : drv ? bit_v : 1'b1;
  always @(posedge card_clk) begin
    if (cmd_oe) cmd_sh <= {cmd_sh[46:0], cmd_out};
  end
  initial begin
    card_clk = 1'b0;
    forever begin
      #100;
      if (run || card_clk) card_clk = ~card_clk;
    end
  end
  initial begin
    drv = 1'b0;
    bit_v = 1'b1;
    forever begin
      @(negedge cmd_oe);
      rsp[47:8] = {2'h0, idx, 32'h0};
      rsp[7:0] = {crc7(rsp[47:8]) ^ {6'h00, mode == 3'h3}, mode != 3'h2};
      if (run && mode < 3'h4 && cmd_sh[7:0] == {crc7(cmd_sh[47:8]), 1'b1}) begin
        repeat (2) @(negedge card_clk);
        drv = 1'b1;
        for (int i = 47; i >= 0; i--) begin
          bit_v = rsp[i];
          @(negedge card_clk);
        end
        drv = 1'b0;
      end
    end
  end
endmodule

/* File: verif/test_sdes_top.sv */
// Bench for the error-status block with a card model on the link.
`timescale 1ns/1ps
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin errors++; \
  $display("ERROR %s exp %h got %h", n, e, a); end end
module test_sdes_top;
  import sdes_pkg::*;
  logic sys_clk, rst, reg_wr, reg_rd, run, dat0, card_clk, cmd_in, cmd_out, cmd_oe, irq;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rd;
  logic [2:0] mode;
  logic [5:0] idx;
  int errors, num_checks;
  sdes_top i_dut (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .card_clk, .cmd_in, .cmd_out, .cmd_oe, .dat0_in(dat0), .irq);
  sdes_card i_card (.run, .card_clk, .cmd_out, .cmd_oe, .cmd_in, .mode, .idx);
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rdr(input logic [3:0] a);
    reg_addr <= a;
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
    rd = reg_rdata;
  endtask
  task automatic xfer(input logic [31:0] c);
    int n;
    run <= 1'b1;
    wr(SDES_ADDR_CTRL, 32'h0010_0205 | c);
    reg_wr <= 1'b0;
    repeat (4) @(posedge sys_clk);
    n = 0;
    do begin
      rdr(SDES_ADDR_STATE);
      n++;
    end while (rd[5:0] !== 6'h01 && n < 2000);
    if (rd[5:0] !== 6'h01) begin
      errors++;
      stop_test();
    end
    run <= 1'b0;
    repeat (16) @(posedge sys_clk);
  endtask
  task automatic t_reset;
    logic [3:0] ad[4] = '{4'h0, 4'h1, 4'h2, 4'hF};
    wr(4'hF, 32'hFFFF_FFFF);
    foreach (ad[i]) begin
      rdr(ad[i]);
      `CHK("reset", 32'h0, rd)
    end
    rdr(SDES_ADDR_CTRL);
    `CHK("ctrl reset", {SDES_TIMEOUT_RST, 16'h0000}, rd)
    $display("test reset done");
  endtask
  task automatic t_errors;
    int md[10] = '{0, 0, 2, 3, 4, 5, 0, 0, 0, 0};
    int cb[10] = '{0, 0, 0, 0, 0, 0, 'h40, 'h80, 'h100, 'h40};
    logic [4:0] ex[10] = '{5'h00, 5'h08, 5'h04, 5'h02, 5'h01, 5'h03, 5'h10, 5'h10,
      5'h10, 5'h00};
    wr(SDES_ADDR_STATEN, 32'h1F);
    for (int i = 0; i < 10; i++) begin
      mode <= 3'(md[i]);
      idx <= (i == 1) ? 6'h06 : 6'h05;
      dat0 <= (i != 6);
      xfer(32'(cb[i]));
      rdr(SDES_ADDR_ERRSTAT);
      `CHK("flags", ex[i], rd[4:0])
      wr(SDES_ADDR_ERRSTAT, 32'h1F);
      rdr(SDES_ADDR_ERRSTAT);
      `CHK("cleared", 5'h00, rd[4:0])
    end
    $display("test errors done");
  endtask
  task automatic t_gate;
    wr(SDES_ADDR_STATEN, 32'h01);
    mode <= 3'h5;
    xfer(32'h0);
    rdr(SDES_ADDR_ERRSTAT);
    `CHK("gated", 5'h01, rd[4:0])
    $display("test gate done");
  endtask
  task automatic t_irq;
    wr(SDES_ADDR_SIGEN, 32'h1E);
    reg_wr <= 1'b0;
    repeat (3) @(posedge sys_clk);
    `CHK("irq masked", 1'b0, irq)
    wr(SDES_ADDR_SIGEN, 32'h01);
    wr(SDES_ADDR_ERRSTAT, 32'h0);
    rdr(SDES_ADDR_ERRSTAT);
    `CHK("kept", 5'h01, rd[4:0])
    `CHK("irq on", 1'b1, irq)
    wr(SDES_ADDR_ERRSTAT, 32'h01);
    reg_wr <= 1'b0;
    repeat (3) @(posedge sys_clk);
    `CHK("irq off", 1'b0, irq)
    $display("test irq done");
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    dat0 = 1'b1;
    {reg_wr, reg_rd, run, mode, idx, reg_addr, reg_wdata} = '0;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset();
    t_errors();
    t_gate();
    t_irq();
    stop_test();
  end
endmodule
